// ==== src/adc_defs.svh ====
`ifndef ADC_DEFS_SVH
`define ADC_DEFS_SVH

`define ADC_OFS_SENSE_FS 8'h19
`define ADC_OFS_CTRL 8'h87
`define ADC_OFS_RES_UP 8'h88
`define ADC_OFS_RES_LO 8'h89

`define ADC_CTRL_TRIG_BIT 7
`define ADC_CTRL_FMT_BIT 6
`define ADC_CTRL_SRC_MSB 3
`define ADC_CTRL_SRC_LSB 0

`define ADC_RST_SENSE_FS 8'h00
`define ADC_RST_SRC 4'h0
`define ADC_RST_RESULT 12'h000

`define ADC_SLAVE_ADDR 7'h48

`define ADC_SYS_CLK_HZ 20000000
`define ADC_CONV_CLK_HZ 4000000
`define ADC_TICK_DIV (`ADC_SYS_CLK_HZ / `ADC_CONV_CLK_HZ)
`define ADC_CONV_MAX_US 3000
`define ADC_CONV_MAX_CYC (`ADC_CONV_MAX_US * (`ADC_SYS_CLK_HZ / 1000000))
`define ADC_WAKE_US 20
`define ADC_WAKE_TICKS (`ADC_WAKE_US * (`ADC_CONV_CLK_HZ / 1000000))

`endif

// ==== src/adc_pkg.sv ====
package adc_pkg;

  typedef enum logic [2:0] {
    LK_IDLE, LK_ADDR, LK_REG, LK_WDATA, LK_ACK, LK_RDATA, LK_MACK
  } link_state_e;

  typedef enum logic [2:0] {
    CV_SLEEP, CV_WAKE, CV_SAMPLE, CV_CONVERT, CV_FINISH
  } conv_state_e;

  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
    logic sda;
  } bus_event_s;

  typedef struct packed {
    logic fmt;
    logic [3:0] src;
  } ctrl_s;

endpackage : adc_pkg

// ==== src/adc_sar_engine.sv ====
`timescale 1ns/10ps
`include "adc_defs.svh"
module adc_sar_engine #(
  parameter int LIMIT_CYC = `ADC_CONV_MAX_CYC,
  parameter int WAKE_TICKS = `ADC_WAKE_TICKS,
  parameter int BITS = 12
) (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic start_in,
  input wire logic [2:0] src_in,
  input wire logic cmp_in,
  output logic [BITS-1:0] dac_code_out,
  output logic [2:0] mux_sel_out,
  output logic sample_out,
  output logic power_save_out,
  output logic idle_out,
  output logic done_out,
  output logic [BITS-1:0] result_out
);

  localparam int DIV = `ADC_TICK_DIV;
  localparam int LW = $clog2(LIMIT_CYC + 1);

  adc_pkg::conv_state_e state_ff, nxt_state;
  logic [$clog2(DIV)-1:0] div_ff;
  logic [LW-1:0] age_ff;
  logic [$clog2(WAKE_TICKS + 1)-1:0] wake_ff;
  logic [$clog2(BITS)-1:0] bit_ff;
  logic [BITS-1:0] code_ff;
  logic [2:0] sel_ff;
  logic done_ff;
  logic [BITS-1:0] res_ff;

  // Conversion steps advance on a 4 MHz tick from the system clock
  wire tick = (div_ff == ($bits(div_ff))'(DIV - 1));
  wire over = (age_ff == LW'(LIMIT_CYC - 1));
  wire wake_done = (wake_ff == '0);
  wire keep_bit = cmp_in;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      adc_pkg::CV_SLEEP: if (start_in) nxt_state = adc_pkg::CV_WAKE;
      adc_pkg::CV_WAKE: if (tick && wake_done) nxt_state = adc_pkg::CV_SAMPLE;
      adc_pkg::CV_SAMPLE: if (tick) nxt_state = adc_pkg::CV_CONVERT;
      adc_pkg::CV_CONVERT: if (tick && bit_ff == '0) begin
        nxt_state = adc_pkg::CV_FINISH;
      end
      adc_pkg::CV_FINISH: nxt_state = adc_pkg::CV_SLEEP;
      default: nxt_state = adc_pkg::CV_SLEEP;
    endcase
    if (over && state_ff != adc_pkg::CV_SLEEP &&
        state_ff != adc_pkg::CV_FINISH) begin
      nxt_state = adc_pkg::CV_FINISH;
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_ff <= adc_pkg::CV_SLEEP;
      div_ff <= '0;
      age_ff <= '0;
      wake_ff <= '0;
      bit_ff <= '0;
      code_ff <= '0;
      sel_ff <= 3'h0;
      done_ff <= 1'b0;
      res_ff <= `ADC_RST_RESULT;
    end else begin
      state_ff <= nxt_state;
      div_ff <= tick ? '0 : div_ff + 1'b1;
      age_ff <= (state_ff == adc_pkg::CV_SLEEP) ? '0 : age_ff + 1'b1;
      done_ff <= (state_ff == adc_pkg::CV_FINISH);
      if (state_ff == adc_pkg::CV_SLEEP && start_in) begin
        sel_ff <= src_in;
        wake_ff <= ($bits(wake_ff))'(WAKE_TICKS);
        bit_ff <= ($bits(bit_ff))'(BITS - 1);
        code_ff <= '0;
      end
      if (state_ff == adc_pkg::CV_WAKE && tick && !wake_done) begin
        wake_ff <= wake_ff - 1'b1;
      end
      if (state_ff == adc_pkg::CV_SAMPLE && tick) begin
        code_ff[bit_ff] <= 1'b1;
      end
      // Trial bit stays when the input is at or above the trial level
      if (state_ff == adc_pkg::CV_CONVERT && tick) begin
        code_ff[bit_ff] <= keep_bit;
        if (bit_ff != '0) begin
          code_ff[bit_ff - 1'b1] <= 1'b1;
          bit_ff <= bit_ff - 1'b1;
        end
      end
      if (state_ff == adc_pkg::CV_FINISH) res_ff <= code_ff;
    end
  end

  assign dac_code_out = code_ff;
  assign mux_sel_out = sel_ff;
  assign sample_out = (state_ff == adc_pkg::CV_SAMPLE);
  assign power_save_out = (state_ff == adc_pkg::CV_SLEEP);
  assign idle_out = (state_ff == adc_pkg::CV_SLEEP);
  assign done_out = done_ff;
  assign result_out = res_ff;

endmodule : adc_sar_engine

// ==== src/housekeeping_adc_control.sv ====
// Summary of operation
// - Conversion steps are timed from a 4 MHz tick; no external clock.
// - Writing the trigger bit in the control register starts a conversion.
// - Result reaches the result registers within 3 ms of the trigger.
// - Result registers are read-only; writes to them are ignored.
// - The eight most significant result bits sit in one register.
// - With the justify bit set, MSB is dropped and the result shifts left.
// - Source field picks one of eight inputs; each conversion yields 12 bits.
// - The converter drops into power save by itself when idle.
// - Source code 0011 routes battery sense voltage, 4.80 V full scale.
// - Die temperature code maps to 390 degrees less 0.16 per step.
// - Discharge full scale follows the sense voltage held at sense_fullscale_select.
`timescale 1ns/10ps
`include "adc_defs.svh"
module housekeeping_adc_control #(
  parameter logic [6:0] SLAVE_ADDR = `ADC_SLAVE_ADDR,
  parameter int CONV_LIMIT_CYC = `ADC_CONV_MAX_CYC,
  parameter int WAKE_TICKS = `ADC_WAKE_TICKS
) (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic cmp_in,
  output logic [11:0] dac_code_out,
  output logic [2:0] mux_sel_out,
  output logic sample_out,
  output logic power_save_out,
  output logic [7:0] sense_fullscale_out
);

  adc_pkg::bus_event_s evt;
  adc_pkg::link_state_e state_ff, nxt_state;
  adc_pkg::link_state_e after_ff, nxt_after;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [7:0] sh_ff, nxt_sh;
  logic [7:0] ptr_ff, nxt_ptr;
  logic rnw_ff, nxt_rnw;
  logic oe_ff, nxt_oe;
  logic wr_en_ff, nxt_wr_en;
  logic [7:0] wr_addr_ff, nxt_wr_addr;
  logic [7:0] wr_data_ff, nxt_wr_data;
  logic sda_drv_ff;

  logic [7:0] sense_fs_ff;
  adc_pkg::ctrl_s ctrl_ff;
  logic trig_ff;
  logic [11:0] result;
  logic eng_idle;
  logic eng_done;
  logic eng_sample;
  logic eng_sleep;
  logic sample_ff;
  logic power_save_ff;

  i2c_bus_sense u_sense (
    .clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .evt_out(evt)
  );

  // Register decode
  wire wr_sense = wr_en_ff && (wr_addr_ff == `ADC_OFS_SENSE_FS);
  wire wr_ctrl = wr_en_ff && (wr_addr_ff == `ADC_OFS_CTRL);
  wire start_conv = trig_ff && eng_idle;
  wire trig_req = wr_ctrl && wr_data_ff[`ADC_CTRL_TRIG_BIT];
  // Sources 8..15 fall back to the external input
  wire [2:0] src_sel = ctrl_ff.src[3] ? 3'h7 : ctrl_ff.src[2:0];

  // Result packing: upper byte always carries the top eight bits shown
  wire [11:0] shown = ctrl_ff.fmt ? {result[10:0], 1'b0} : result;
  wire [7:0] res_upper = shown[11:4];
  wire [7:0] res_lower = {shown[3:0], 4'h0};
  wire [7:0] ctrl_rd = {trig_ff, ctrl_ff.fmt, 2'h0, ctrl_ff.src};

  wire hit_sense = (ptr_ff == `ADC_OFS_SENSE_FS);
  wire hit_ctrl = (ptr_ff == `ADC_OFS_CTRL);
  wire hit_up = (ptr_ff == `ADC_OFS_RES_UP);
  wire hit_lo = (ptr_ff == `ADC_OFS_RES_LO);
  wire [7:0] rd_data = hit_sense ? sense_fs_ff :
                       hit_ctrl ? ctrl_rd :
                       hit_up ? res_upper :
                       hit_lo ? res_lower : 8'h00;

  wire addr_match = (sh_ff[7:1] == SLAVE_ADDR);
  // A byte is complete at the clock fall after its eighth bit
  wire byte_done = evt.fall && (cnt_ff == 4'h8);

  // Serial register access, byte-wise with auto-increment
  always_comb begin
    nxt_state = state_ff;
    nxt_after = after_ff;
    nxt_cnt = cnt_ff;
    nxt_sh = sh_ff;
    nxt_ptr = ptr_ff;
    nxt_rnw = rnw_ff;
    nxt_oe = oe_ff;
    nxt_wr_en = 1'b0;
    nxt_wr_addr = wr_addr_ff;
    nxt_wr_data = wr_data_ff;
    if (evt.stop) begin
      nxt_state = adc_pkg::LK_IDLE;
      nxt_oe = 1'b0;
    end else if (evt.start) begin
      nxt_state = adc_pkg::LK_ADDR;
      nxt_cnt = 4'h0;
      nxt_oe = 1'b0;
    end else begin
      unique case (state_ff)
        adc_pkg::LK_IDLE: begin
          nxt_oe = 1'b0;
        end
        adc_pkg::LK_ADDR, adc_pkg::LK_REG, adc_pkg::LK_WDATA: begin
          if (evt.rise && cnt_ff != 4'h8) begin
            nxt_sh = {sh_ff[6:0], evt.sda};
            nxt_cnt = cnt_ff + 4'h1;
          end
          if (byte_done) begin
            nxt_oe = 1'b1;
            nxt_state = adc_pkg::LK_ACK;
            if (state_ff == adc_pkg::LK_ADDR) begin
              nxt_rnw = sh_ff[0];
              nxt_after = sh_ff[0] ? adc_pkg::LK_RDATA : adc_pkg::LK_REG;
              if (!addr_match) begin
                nxt_oe = 1'b0;
                nxt_state = adc_pkg::LK_IDLE;
              end
            end else if (state_ff == adc_pkg::LK_REG) begin
              nxt_ptr = sh_ff;
              nxt_after = adc_pkg::LK_WDATA;
            end else begin
              nxt_wr_en = 1'b1;
              nxt_wr_addr = ptr_ff;
              nxt_wr_data = sh_ff;
              nxt_ptr = ptr_ff + 8'h01;
              nxt_after = adc_pkg::LK_WDATA;
            end
          end
        end
        adc_pkg::LK_ACK: begin
          if (evt.fall) begin
            nxt_state = after_ff;
            if (after_ff == adc_pkg::LK_RDATA) begin
              nxt_sh = rd_data;
              nxt_oe = ~rd_data[7];
              nxt_cnt = 4'h1;
            end else begin
              nxt_oe = 1'b0;
              nxt_cnt = 4'h0;
            end
          end
        end
        adc_pkg::LK_RDATA: begin
          if (evt.fall) begin
            if (cnt_ff != 4'h8) begin
              nxt_sh = {sh_ff[6:0], 1'b0};
              nxt_oe = ~sh_ff[6];
              nxt_cnt = cnt_ff + 4'h1;
            end else begin
              nxt_oe = 1'b0;
              nxt_state = adc_pkg::LK_MACK;
            end
          end
        end
        adc_pkg::LK_MACK: begin
          if (evt.rise) begin
            if (!evt.sda) begin
              nxt_ptr = ptr_ff + 8'h01;
              nxt_after = adc_pkg::LK_RDATA;
              nxt_state = adc_pkg::LK_ACK;
            end else begin
              nxt_state = adc_pkg::LK_IDLE;
            end
          end
        end
        // Unused state code: let go of the bus and wait for a start
        default: begin
          nxt_state = adc_pkg::LK_IDLE;
          nxt_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_ff <= adc_pkg::LK_IDLE;
      after_ff <= adc_pkg::LK_IDLE;
      cnt_ff <= 4'h0;
      sh_ff <= 8'h00;
      ptr_ff <= 8'h00;
      rnw_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      after_ff <= nxt_after;
      cnt_ff <= nxt_cnt;
      sh_ff <= nxt_sh;
      ptr_ff <= nxt_ptr;
      rnw_ff <= nxt_rnw;
      oe_ff <= nxt_oe;
    end
  end

  // Write strobe lands one clock after the byte ends, inside the ack bit
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_en_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      wr_data_ff <= 8'h00;
      sda_drv_ff <= 1'b0;
    end else begin
      wr_en_ff <= nxt_wr_en;
      wr_addr_ff <= nxt_wr_addr;
      wr_data_ff <= nxt_wr_data;
      sda_drv_ff <= 1'b0;
    end
  end

  // Only sense_fullscale_select and converter_control take writes; result offsets fall through untouched
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sense_fs_ff <= `ADC_RST_SENSE_FS;
      ctrl_ff.fmt <= 1'b0;
      ctrl_ff.src <= `ADC_RST_SRC;
    end else begin
      if (wr_sense) sense_fs_ff <= wr_data_ff;
      if (wr_ctrl) begin
        ctrl_ff.fmt <= wr_data_ff[`ADC_CTRL_FMT_BIT];
        ctrl_ff.src <= wr_data_ff[`ADC_CTRL_SRC_MSB:`ADC_CTRL_SRC_LSB];
      end
    end
  end

  // Trigger is set by the host and cleared when the converter takes it;
  // a new request in the same cycle keeps it set
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      trig_ff <= 1'b0;
    end else begin
      trig_ff <= trig_req | (trig_ff & ~start_conv);
    end
  end

  adc_sar_engine #(
    .LIMIT_CYC(CONV_LIMIT_CYC),
    .WAKE_TICKS(WAKE_TICKS),
    .BITS(12)
  ) u_engine (
    .clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in),
    .start_in(start_conv),
    .src_in(src_sel),
    .cmp_in(cmp_in),
    .dac_code_out(dac_code_out),
    .mux_sel_out(mux_sel_out),
    .sample_out(eng_sample),
    .power_save_out(eng_sleep),
    .idle_out(eng_idle),
    .done_out(eng_done),
    .result_out(result)
  );

  // Converter status leaves through flops so the pins carry no decode glitch
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sample_ff <= 1'b0;
      power_save_ff <= 1'b1;
    end else begin
      sample_ff <= eng_sample;
      power_save_ff <= eng_sleep;
    end
  end

  assign sample_out = sample_ff;
  assign power_save_out = power_save_ff;
  assign sda_out = sda_drv_ff;
  assign sda_oe_out = oe_ff;
  assign sense_fullscale_out = sense_fs_ff;

endmodule : housekeeping_adc_control

// ==== src/i2c_bus_sense.sv ====
`timescale 1ns/10ps
module i2c_bus_sense (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output adc_pkg::bus_event_s evt_out
);

  logic scl_ff;
  logic sda_ff;
  adc_pkg::bus_event_s evt_ff;
  adc_pkg::bus_event_s nxt_evt;

  // Start and stop are sda edges while scl stays high
  assign nxt_evt.start = scl_ff & scl_in & sda_ff & ~sda_in;
  assign nxt_evt.stop = scl_ff & scl_in & ~sda_ff & sda_in;
  assign nxt_evt.rise = ~scl_ff & scl_in;
  assign nxt_evt.fall = scl_ff & ~scl_in;
  assign nxt_evt.sda = sda_in;

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
      evt_ff <= '0;
    end else begin
      scl_ff <= scl_in;
      sda_ff <= sda_in;
      evt_ff <= nxt_evt;
    end
  end

  assign evt_out = evt_ff;

endmodule : i2c_bus_sense

// ==== verification/adc_ctl_monitor.sv ====
`timescale 1ns/10ps
module adc_ctl_monitor #(
  parameter int CONV_LIMIT_CYC = 60000
) (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic cmp_in,
  input wire logic [11:0] dac_code_out,
  input wire logic [2:0] mux_sel_out,
  input wire logic sample_out,
  input wire logic power_save_out,
  input wire logic [7:0] sense_fullscale_out
);
  int busy_cnt;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  // Cycles spent awake in the current conversion
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) busy_cnt <= 0;
    else if (power_save_out) busy_cnt <= 0;
    else busy_cnt <= busy_cnt + 1;
  end
  property p_ack_low; sda_oe_out |-> !sda_out; endproperty
  a_ack_low: assert property (p_ack_low)
    else $error("data pin driven high");
  property p_sda_hold; scl_in && $past(scl_in) |-> $stable(sda_oe_out);
  endproperty
  a_sda_hold: assert property (p_sda_hold)
    else $error("data drive changed while clock high");
  property p_tick; $rose(sample_out) |-> sample_out[*5] ##1 !sample_out;
  endproperty
  a_tick: assert property (p_tick)
    else $error("sample pulse is not one 4 MHz tick");
  property p_awake; sample_out |-> !power_save_out; endproperty
  a_awake: assert property (p_awake)
    else $error("sampling while in power save");
  property p_mux_hold; $fell(sample_out) |-> $stable(mux_sel_out)[*8];
  endproperty
  a_mux_hold: assert property (p_mux_hold)
    else $error("source changed during conversion");
  property p_conv_bound; busy_cnt <= CONV_LIMIT_CYC + 10; endproperty
  a_conv_bound: assert property (p_conv_bound)
    else $error("conversion overran its limit");
  property p_sleep_after;
    $fell(sample_out) |-> ##[1:100] $rose(power_save_out);
  endproperty
  a_sleep_after: assert property (p_sleep_after)
    else $error("no power save after conversion");
  property p_fs_write; $changed(sense_fullscale_out) |-> sda_oe_out;
  endproperty
  a_fs_write: assert property (p_fs_write)
    else $error("full scale changed outside a bus write");
endmodule : adc_ctl_monitor

bind housekeeping_adc_control adc_ctl_monitor #(
  .CONV_LIMIT_CYC(CONV_LIMIT_CYC)
) u_mon (
  .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
  .cmp_in(cmp_in), .dac_code_out(dac_code_out),
  .mux_sel_out(mux_sel_out), .sample_out(sample_out),
  .power_save_out(power_save_out),
  .sense_fullscale_out(sense_fullscale_out)
);

// ==== verification/host_model.sv ====
`timescale 1ns/10ps
module host_model #(
  parameter logic [6:0] SLAVE = 7'h48
) (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  logic [7:0] got;
  event got_ev;
  initial begin
    scl_out = 1'h1;
    sda_low_out = 1'h0;
  end
  task automatic hp();
    repeat (6) @(negedge clk_in);
  endtask : hp
  // Data moves only while the clock is low; sampled late in the high phase
  task automatic bit_io(input logic b, output logic r);
    sda_low_out = !b;
    hp();
    scl_out = 1'h1;
    hp();
    r = sda_in;
    scl_out = 1'h0;
    hp();
  endtask : bit_io
  task automatic xfer(input logic [7:0] d, input logic ab,
    output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(ab, r);
    ack = !r;
  endtask : xfer
  task automatic start();
    sda_low_out = 1'h0;
    hp();
    scl_out = 1'h1;
    hp();
    sda_low_out = 1'h1;
    hp();
    scl_out = 1'h0;
    hp();
  endtask : start
  task automatic stop();
    sda_low_out = 1'h1;
    hp();
    scl_out = 1'h1;
    hp();
    sda_low_out = 1'h0;
    hp();
  endtask : stop
  task automatic write_reg(input logic [6:0] sa, input logic [7:0] a,
    input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic k0, k1, k2;
    start();
    xfer({sa, 1'h0}, 1'h1, q, k0);
    xfer(a, 1'h1, q, k1);
    xfer(d, 1'h1, q, k2);
    stop();
    ok = k0 & k1 & k2;
  endtask : write_reg
  // Two bytes from a: the first acked, the second refused
  task automatic read_two(input logic [7:0] a, output logic ok);
    logic k0, k1, k2, k3;
    start();
    xfer({SLAVE, 1'h0}, 1'h1, got, k0);
    xfer(a, 1'h1, got, k1);
    start();
    xfer({SLAVE, 1'h1}, 1'h1, got, k2);
    xfer(8'hFF, 1'h0, got, k3);
    ->got_ev;
    xfer(8'hFF, 1'h1, got, k3);
    ->got_ev;
    stop();
    ok = k0 & k1 & k2;
  endtask : read_two
endmodule : host_model

// ==== verification/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
  localparam int LIM = 2000;
  localparam logic [6:0] SA = 7'h48;
  logic clk_sys_in = 1'h0;
  logic arst_n_in = 1'h0;
  logic cmp_in = 1'h0;
  logic scl, sda_low, sda, sda_out, sda_oe_out, sample_out, power_save_out;
  logic [11:0] dac_code_out;
  logic [2:0] mux_sel_out;
  logic [7:0] sense_fullscale_out;
  logic [11:0] ain [8];
  logic [7:0] exp_q [$];
  int n_fail = 0;
  int tests_run = 0;

  always #25 clk_sys_in = ~clk_sys_in;
  // Open-drain data wire with pull-up
  assign sda = !(sda_low || (sda_oe_out && !sda_out));
  // Ideal analog side: comparator on the routed source level
  always @(negedge clk_sys_in) cmp_in <= ain[mux_sel_out] >= dac_code_out;

  housekeeping_adc_control #(
    .SLAVE_ADDR(SA), .CONV_LIMIT_CYC(LIM), .WAKE_TICKS(2)
  ) dut (
    .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .cmp_in(cmp_in), .dac_code_out(dac_code_out),
    .mux_sel_out(mux_sel_out), .sample_out(sample_out),
    .power_save_out(power_save_out),
    .sense_fullscale_out(sense_fullscale_out)
  );
  host_model #(.SLAVE(SA)) host (
    .clk_in(clk_sys_in), .sda_in(sda), .scl_out(scl), .sda_low_out(sda_low)
  );

  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t: got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("mismatches %0d of %0d checks", n_fail, tests_run);
    if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    host.write_reg(SA, a, d, ok);
    check(ok, 1'h1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e0,
    input logic [7:0] e1);
    logic ok;
    exp_q.push_back(e0);
    exp_q.push_back(e1);
    host.read_two(a, ok);
    check(ok, 1'h1);
  endtask : rd
  task automatic rd_res(input logic [11:0] r, input logic fmt);
    if (fmt) rd(8'h88, r[10:3], {r[2:0], 5'h00});
    else rd(8'h88, r[11:4], {r[3:0], 4'h0});
  endtask : rd_res
  task automatic convert(input logic [3:0] src, input logic fmt);
    int n;
    logic [11:0] r;
    r = ain[(src > 4'h7) ? 3'h7 : src[2:0]];
    wr(8'h87, {1'h1, fmt, 2'h0, src});
    check(power_save_out, 1'h0);
    n = 0;
    while (power_save_out !== 1'h1 && n < LIM) begin
      @(negedge clk_sys_in);
      n++;
    end
    check(n < LIM, 1'h1);
    rd_res(r, fmt);
    rd(8'h86, 8'h00, {1'h0, fmt, 2'h0, src});
  endtask : convert

  // Result bytes come back in the order they were noted
  initial forever begin
    @(host.got_ev);
    check(host.got, exp_q.pop_front());
  end

  initial begin
    // About 50,000 clocks, near twice the length of the full sequence
    #(2_500_000);
    n_fail++;
    give_verdict();
  end

  initial begin
    logic [7:0] v;
    logic ok;
    void'($urandom(32'h1684));
    foreach (ain[i]) ain[i] = 12'($urandom);
    ain[0] = 12'h000;
    ain[3] = 12'hFFF;
    repeat (3) @(negedge clk_sys_in);
    arst_n_in = 1'h1;
    repeat (3) @(negedge clk_sys_in);
    check(power_save_out, 1'h1);
    rd(8'h88, 8'h00, 8'h00);
    for (int s = 0; s < 9; s++) convert((s == 8) ? 4'hC : 4'(s), s[0]);
    wr(8'h87, 8'h43);
    rd_res(ain[7], 1'h1);
    wr(8'h88, 8'h5A);
    wr(8'h89, 8'hA5);
    rd_res(ain[7], 1'h1);
    v = 8'($urandom);
    wr(8'h19, v);
    check(sense_fullscale_out, v);
    rd(8'h18, 8'h00, v);
    host.write_reg(SA ^ 7'h01, 8'h87, 8'h80, ok);
    check(ok, 1'h0);
    check(power_save_out, 1'h1);
    arst_n_in = 1'h0;
    @(negedge clk_sys_in);
    arst_n_in = 1'h1;
    repeat (2) @(negedge clk_sys_in);
    rd(8'h88, 8'h00, 8'h00);
    give_verdict();
  end
endmodule : tb_top
